/* oscc_pkg.sv */
// Package for the oscillator source control block.
// Holds register offsets, field positions, reset values and timing counts.
// Assumes a single 20 MHz system clock and an Avalon-MM register port.
package oscc_pkg;
	// System clock rate and period
	localparam int CLK_HZ = 20_000_000;
	localparam int CLK_PERIOD_NS = 50;

	// Register byte offsets
	localparam logic [7:0] ADDR_FREQ_SEL = 8'h00;
	localparam logic [7:0] ADDR_TRIM = 8'h04;
	localparam logic [7:0] ADDR_DRIVE = 8'h08;
	localparam logic [7:0] ADDR_FORCE_ON = 8'h0c;
	localparam logic [7:0] ADDR_READY = 8'h10;
	localparam logic [7:0] ADDR_SOURCE = 8'h14;

	// Field widths
	localparam int FREQ_W = 3;
	localparam int TRIM_W = 6;
	localparam int FORCE_W = 5;
	localparam int READY_W = 6;

	// Force-on register bit positions
	localparam int FORCE_HF_BIT = 0;
	localparam int FORCE_MID_BIT = 1;
	localparam int FORCE_LF_BIT = 2;
	localparam int FORCE_SEC_BIT = 3;
	localparam int FORCE_CONV_BIT = 4;

	// Ready register bit positions
	localparam int RDY_HF_BIT = 0;
	localparam int RDY_MID_BIT = 1;
	localparam int RDY_LF_BIT = 2;
	localparam int RDY_SEC_BIT = 3;
	localparam int RDY_CONV_BIT = 4;
	localparam int RDY_1MHZ_BIT = 5;

	// Reset values
	localparam logic [TRIM_W-1:0] TRIM_RST = 6'h00;
	localparam logic DRIVE_RST = 1'h1;
	localparam logic [FORCE_W-1:0] FORCE_RST = 5'h00;
	localparam logic [FREQ_W-1:0] FREQ_1MHZ = 3'h0;
	localparam logic [FREQ_W-1:0] FREQ_32MHZ = 3'h5;

	// Reset clock select codes
	localparam logic [2:0] SEL_EXT = 3'h7;
	localparam logic [2:0] SEL_HF_1MHZ = 3'h6;
	localparam logic [2:0] SEL_LF = 3'h5;
	localparam logic [2:0] SEL_SEC = 3'h4;
	localparam logic [2:0] SEL_HF_32MHZ = 3'h0;

	// External clock mode codes
	localparam logic [1:0] EXT_HIGH_POWER = 2'h3;
	localparam logic [1:0] EXT_LOW_POWER = 2'h1;

	// Secondary oscillator start-up period count
	localparam int STARTUP_PERIODS = 1024;

	// Fixed divided clock rates and their half-period counts
	localparam int ONE_MHZ_HZ = 1_000_000;
	localparam int MID_500K_HZ = 500_000;
	localparam int MID_31K25_HZ = 31_250;
	localparam int LF_HZ = 31_000;
	localparam int HALF_1MHZ = CLK_HZ / (2 * ONE_MHZ_HZ);
	localparam int HALF_500K = CLK_HZ / (2 * MID_500K_HZ);
	localparam int HALF_31K25 = CLK_HZ / (2 * MID_31K25_HZ);
	localparam int HALF_LF = CLK_HZ / (2 * LF_HZ);

	// Settling times in ns and their cycle counts (least times round up)
	localparam int HF_LOCK_NS = 2000;
	localparam int HF_LOCK_CYC = (HF_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TRIM_STEP_NS = 500;
	localparam int TRIM_STEP_CYC = (TRIM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 10;
endpackage

/* oscc_startup_counter.sv */
// Start-up period counter for the secondary 32 kHz oscillator.
// Assumes the oscillator level is already synchronised to i_clk.
`timescale 1ns/10ps
`default_nettype none
module oscc_startup_counter #(
	parameter int PERIODS = oscc_pkg::STARTUP_PERIODS
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_restart,
	input wire logic i_enable,
	input wire logic i_osc_level,
	output logic o_ready
);
	// Counter wide enough to hold the full period count
	logic [$clog2(PERIODS+1)-1:0] cnt_ff;
	logic prev_ff;
	logic ready_ff;
	wire rise = i_osc_level & ~prev_ff;
	wire done = (cnt_ff == ($clog2(PERIODS+1))'(PERIODS));

	// Previous level for edge detection
	always_ff @(posedge i_clk) begin
		if (!i_reset_n)
			prev_ff <= 1'h0;
		else
			prev_ff <= i_osc_level;
	end

	// Count rising edges; a restart or disable starts over with ready low
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || i_restart || !i_enable) begin
			cnt_ff <= '0;
			ready_ff <= 1'h0;
		end else if (done) begin
			ready_ff <= 1'h1;
		end else if (rise) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	assign o_ready = ready_ff;
endmodule
`default_nettype wire

/* oscc_source_control.sv */
// Oscillator source control: source latch, divided clocks, trim, ready flags.
// Assumes fuse inputs are steady; pins arrive asynchronously.
// Overview of operation
// RQ1: Source fixed from fuses, never switched later
// RQ2: Software changes HF frequency via select field
// RQ3: Fuse low drives Fosc/4 on clock output
// RQ4: Select 111 uses external clock input
// RQ5: Host picks external power mode by frequency
// RQ6: External mode bypasses the start-up counter
// RQ7: Fully static; stopped clock keeps all state
// RQ8: Secondary enabled by fuse select or bit
// RQ9: Drive bit: 0 low power, 1 high
// RQ10: Software disables secondary before drive change
// RQ11: Count 1024 crystal periods, then ready
// RQ12: Internal source frees clock pins as GPIO
// RQ13: Trim is signed 6-bit, resets to zero
// RQ14: Trim write slews gradually, no indication
// RQ15: Low-frequency oscillator ignores the trim
// RQ16: Fixed 500 kHz and 31.25 kHz clocks
// RQ17: Fixed 1 MHz clock from HF oscillator
// RQ18: Fixed 31 kHz oscillator and timer base
// RQ19: Converter RC on when selected or forced
// RQ20: Ready flags set once oscillators settle
// RQ21: Frequency write clears ready, holds clock
// RQ22: Force-on bits for every oscillator
// RQ23: Select codes choose startup source
// RQ24: Secondary ready reads zero until counted
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module oscc_source_control #(
	parameter int HF_LOCK_CYCLES = oscc_pkg::HF_LOCK_CYC,
	parameter int SETTLE_CYCLES = oscc_pkg::SETTLE_CYC
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic [2:0] i_reset_clock_select,
	input wire logic [1:0] i_external_clock_mode_select,
	input wire logic i_clock_output_enable_n,
	input wire logic i_clock_input_pin,
	input wire logic i_secondary_crystal_in,
	input wire logic i_gpio_out_data,
	input wire logic i_gpio_out_oe,
	input wire logic i_wake_pulse,
	input wire logic i_por_bor_pulse,
	input wire logic i_converter_clk_request,
	output logic [2:0] o_sys_source,
	output logic o_sys_clock_ready,
	output logic o_external_high_power_mode,
	output logic o_external_clock_level,
	output logic o_clock_output_pin,
	output logic o_clock_output_pin_oe,
	output logic o_clock_input_pin_is_gpio,
	output logic o_high_freq_internal_osc,
	output logic [5:0] o_hf_trim_applied,
	output logic o_mid_500k_clock,
	output logic o_mid_31k25_clock,
	output logic o_fixed_1mhz_divided_clock,
	output logic o_low_freq_internal_osc,
	output logic o_secondary_osc_en,
	output logic o_secondary_osc_drive_select,
	output logic o_converter_rc_osc_en,
	output logic o_hf_osc_en
);
	localparam int W = oscc_pkg::CNT_W;

	// True when a free-running counter reaches its last count
	function automatic logic at_limit(input logic [W-1:0] cnt, input int lim);
		at_limit = (cnt == W'(lim - 1));
	endfunction

	// HF oscillator state, one-hot
	typedef enum logic [1:0] {HF_RUN = 2'b01, HF_LOCK = 2'b10} oscc_hf_state_t;

	// Configuration latch
	logic cfg_loaded_ff; // Fuses captured after reset release
	logic [2:0] src_ff; // Fixed system clock source
	logic clock_output_pin_en_n_ff; // Captured clock-output fuse
	logic [1:0] ext_mode_ff; // Captured external power mode
	// Software registers
	logic [oscc_pkg::FREQ_W-1:0] freq_ff;
	logic [oscc_pkg::TRIM_W-1:0] trim_target_ff;
	logic [oscc_pkg::TRIM_W-1:0] trim_applied_ff;
	logic drive_ff;
	logic [oscc_pkg::FORCE_W-1:0] force_ff;
	// Bus slave
	logic wait_ff;
	logic [31:0] rdata_ff;
	// Pin synchronisers
	logic [1:0] xtal_sync_ff;
	logic [1:0] clock_input_pin_sync_ff;
	// Oscillator state
	oscc_hf_state_t hf_state_ff;
	logic [W-1:0] hf_cnt_ff; // Lock wait or HF half-period
	logic hf_clk_ff;
	logic [W-1:0] trim_cnt_ff;
	logic [W-1:0] c1m_ff, c500_ff, c31_ff, clf_ff;
	logic [W-1:0] lf_settle_ff, conv_settle_ff;
	logic lf_rdy_ff, conv_rdy_ff, hf_rdy_ff;
	// Registered outputs
	logic clk1m_ff, clk500_ff, clk31_ff, clklf_ff, div4_ff, div4_ph_ff;
	logic pin_ff, pin_oe_ff, gpio_in_ff, ext_lvl_ff;
	logic sec_en_ff, conv_en_ff, hf_en_ff, sys_rdy_ff, ext_hp_ff;
	logic sec_rdy;

	// Bus decode
	wire req = i_avs_read | i_avs_write;
	wire take = req & ~wait_ff; // Edge where the master sees waitrequest low
	wire wr = i_avs_write & take;
	wire wr_freq = wr & (i_avs_address == oscc_pkg::ADDR_FREQ_SEL);
	wire wr_trim = wr & (i_avs_address == oscc_pkg::ADDR_TRIM);
	wire wr_drive = wr & (i_avs_address == oscc_pkg::ADDR_DRIVE);
	wire wr_force = wr & (i_avs_address == oscc_pkg::ADDR_FORCE_ON);
	// RQ23 startup source decode
	wire src_hf = (src_ff == oscc_pkg::SEL_HF_1MHZ) | (src_ff == oscc_pkg::SEL_HF_32MHZ);
	wire src_ext = (src_ff == oscc_pkg::SEL_EXT);
	wire src_sec = (src_ff == oscc_pkg::SEL_SEC);
	wire src_lf = (src_ff == oscc_pkg::SEL_LF);
	// RQ8 secondary enable terms
	wire nxt_sec_en = cfg_loaded_ff & (src_sec | force_ff[oscc_pkg::FORCE_SEC_BIT]);
	// RQ19 converter RC auto or forced enable
	wire nxt_conv_en = i_converter_clk_request | force_ff[oscc_pkg::FORCE_CONV_BIT];
	// RQ22 HF runs for the source, its force bit, or the mid clocks
	wire nxt_hf_en = cfg_loaded_ff & (src_hf | force_ff[oscc_pkg::FORCE_HF_BIT]
		| force_ff[oscc_pkg::FORCE_MID_BIT]);
	wire hf_rdy_eff = hf_rdy_ff & hf_en_ff;
	wire [oscc_pkg::READY_W-1:0] ready_bits = {hf_rdy_eff, conv_rdy_ff, sec_rdy, lf_rdy_ff, hf_rdy_eff, hf_rdy_eff};
	wire [31:0] nxt_rdata =
		(i_avs_address == oscc_pkg::ADDR_FREQ_SEL) ? {29'h0, freq_ff} :
		(i_avs_address == oscc_pkg::ADDR_TRIM) ? {26'h0, trim_target_ff} :
		(i_avs_address == oscc_pkg::ADDR_DRIVE) ? {31'h0, drive_ff} :
		(i_avs_address == oscc_pkg::ADDR_FORCE_ON) ? {27'h0, force_ff} :
		(i_avs_address == oscc_pkg::ADDR_READY) ? {26'h0, ready_bits} :
		(i_avs_address == oscc_pkg::ADDR_SOURCE) ? {29'h0, src_ff} : 32'h0;
	// Trim slew direction, signed compare
	wire trim_up = $signed(trim_target_ff) > $signed(trim_applied_ff);
	wire trim_dn = $signed(trim_target_ff) < $signed(trim_applied_ff);

	// Avalon slave: one wait cycle, then the request completes
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			wait_ff <= 1'h1;
			rdata_ff <= 32'h0;
		end else begin
			wait_ff <= ~(req & wait_ff);
			if (req & wait_ff)
				rdata_ff <= nxt_rdata;
		end
	end

	// RQ1 latch source once after reset release; no register writes it
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			cfg_loaded_ff <= 1'h0;
			src_ff <= oscc_pkg::SEL_HF_1MHZ;
			clock_output_pin_en_n_ff <= 1'h1;
			ext_mode_ff <= oscc_pkg::EXT_LOW_POWER;
		end else if (!cfg_loaded_ff) begin
			cfg_loaded_ff <= 1'h1;
			src_ff <= i_reset_clock_select;
			clock_output_pin_en_n_ff <= i_clock_output_enable_n;
			ext_mode_ff <= i_external_clock_mode_select;
		end
	end

	// Software registers; RQ13 trim resets to zero, signed field
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			trim_target_ff <= oscc_pkg::TRIM_RST;
			drive_ff <= oscc_pkg::DRIVE_RST;
			force_ff <= oscc_pkg::FORCE_RST;
		end else begin
			if (wr_trim)
				trim_target_ff <= i_avs_writedata[oscc_pkg::TRIM_W-1:0];
			// RQ9 drive select bit; caller disables first (RQ10)
			if (wr_drive)
				drive_ff <= i_avs_writedata[0];
			if (wr_force)
				force_ff <= i_avs_writedata[oscc_pkg::FORCE_W-1:0];
		end
	end

	// RQ14 applied trim steps one code per interval toward the target
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			trim_applied_ff <= oscc_pkg::TRIM_RST;
			trim_cnt_ff <= '0;
		end else if (at_limit(trim_cnt_ff, oscc_pkg::TRIM_STEP_CYC)) begin
			trim_cnt_ff <= '0;
			if (trim_up)
				trim_applied_ff <= trim_applied_ff + 6'h01;
			else if (trim_dn)
				trim_applied_ff <= trim_applied_ff - 6'h01;
		end else begin
			trim_cnt_ff <= trim_cnt_ff + 1'b1;
		end
	end

	// RQ2 RQ21 frequency select, relock and hold of the HF output
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			freq_ff <= oscc_pkg::FREQ_1MHZ;
			hf_state_ff <= HF_LOCK;
			hf_cnt_ff <= '0;
			hf_clk_ff <= 1'h0;
			hf_rdy_ff <= 1'h0;
		end else if (!cfg_loaded_ff) begin
			// RQ23 reset frequency follows the startup selection
			freq_ff <= (i_reset_clock_select == oscc_pkg::SEL_HF_32MHZ) ? oscc_pkg::FREQ_32MHZ
				: oscc_pkg::FREQ_1MHZ;
		end else if (wr_freq) begin
			// New value: drop ready, freeze the output level
			freq_ff <= i_avs_writedata[oscc_pkg::FREQ_W-1:0];
			hf_state_ff <= HF_LOCK;
			hf_cnt_ff <= '0;
			hf_rdy_ff <= 1'h0;
		end else begin
			case (hf_state_ff)
				HF_LOCK: begin
					if (at_limit(hf_cnt_ff, HF_LOCK_CYCLES)) begin
						hf_state_ff <= HF_RUN;
						hf_cnt_ff <= '0;
						hf_rdy_ff <= 1'h1;
					end else begin
						hf_cnt_ff <= hf_cnt_ff + 1'b1;
					end
				end
				HF_RUN: begin
					// Model rate: half period of freq+1 cycles
					if (hf_cnt_ff >= W'(freq_ff)) begin
						hf_cnt_ff <= '0;
						hf_clk_ff <= ~hf_clk_ff;
					end else begin
						hf_cnt_ff <= hf_cnt_ff + 1'b1;
					end
				end
				default: begin
					hf_state_ff <= HF_LOCK;
					hf_cnt_ff <= '0;
				end
			endcase
		end
	end

	// RQ16 RQ17 fixed-rate dividers ignore the frequency select
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || !hf_en_ff) begin
			c1m_ff <= '0;
			c500_ff <= '0;
			c31_ff <= '0;
			clk1m_ff <= 1'h0;
			clk500_ff <= 1'h0;
			clk31_ff <= 1'h0;
		end else begin
			c1m_ff <= at_limit(c1m_ff, oscc_pkg::HALF_1MHZ) ? '0 : c1m_ff + 1'b1;
			c500_ff <= at_limit(c500_ff, oscc_pkg::HALF_500K) ? '0 : c500_ff + 1'b1;
			c31_ff <= at_limit(c31_ff, oscc_pkg::HALF_31K25) ? '0 : c31_ff + 1'b1;
			if (at_limit(c1m_ff, oscc_pkg::HALF_1MHZ))
				clk1m_ff <= ~clk1m_ff;
			if (at_limit(c500_ff, oscc_pkg::HALF_500K))
				clk500_ff <= ~clk500_ff;
			if (at_limit(c31_ff, oscc_pkg::HALF_31K25))
				clk31_ff <= ~clk31_ff;
		end
	end

	// RQ18 RQ15 LF oscillator runs always for the timers, trim never reaches it
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			clf_ff <= '0;
			clklf_ff <= 1'h0;
		end else begin
			clf_ff <= at_limit(clf_ff, oscc_pkg::HALF_LF) ? '0 : clf_ff + 1'b1;
			if (at_limit(clf_ff, oscc_pkg::HALF_LF))
				clklf_ff <= ~clklf_ff;
		end
	end

	// RQ20 settle counters for LF and converter RC ready flags
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			lf_settle_ff <= '0;
			lf_rdy_ff <= 1'h0;
		end else if (at_limit(lf_settle_ff, SETTLE_CYCLES)) begin
			lf_rdy_ff <= 1'h1;
		end else begin
			lf_settle_ff <= lf_settle_ff + 1'b1;
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || !conv_en_ff) begin
			conv_settle_ff <= '0;
			conv_rdy_ff <= 1'h0;
		end else if (at_limit(conv_settle_ff, SETTLE_CYCLES)) begin
			conv_rdy_ff <= 1'h1;
		end else begin
			conv_settle_ff <= conv_settle_ff + 1'b1;
		end
	end

	// Pin synchronisers; only the second stage is read
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			xtal_sync_ff <= 2'h0;
			clock_input_pin_sync_ff <= 2'h0;
		end else begin
			xtal_sync_ff <= {xtal_sync_ff[0], i_secondary_crystal_in};
			clock_input_pin_sync_ff <= {clock_input_pin_sync_ff[0], i_clock_input_pin};
		end
	end

	// RQ11 RQ24 start-up count restarts on reset events and wake
	oscc_startup_counter u_startup (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_restart(i_wake_pulse | i_por_bor_pulse),
		.i_enable(sec_en_ff),
		.i_osc_level(xtal_sync_ff[1]),
		.o_ready(sec_rdy)
	);

	// RQ3 RQ12 clock output pin: Fosc/4 when fuse low, else plain I/O
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			div4_ph_ff <= 1'h0;
			div4_ff <= 1'h0;
			pin_ff <= 1'h0;
			pin_oe_ff <= 1'h0;
		end else begin
			div4_ph_ff <= ~div4_ph_ff;
			if (div4_ph_ff)
				div4_ff <= ~div4_ff;
			pin_ff <= clock_output_pin_en_n_ff ? i_gpio_out_data : div4_ff;
			pin_oe_ff <= clock_output_pin_en_n_ff ? i_gpio_out_oe : cfg_loaded_ff;
		end
	end

	// Enables, source status and the external clock path
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			sec_en_ff <= 1'h0;
			conv_en_ff <= 1'h0;
			hf_en_ff <= 1'h0;
			sys_rdy_ff <= 1'h0;
			gpio_in_ff <= 1'h0;
			ext_lvl_ff <= 1'h0;
			ext_hp_ff <= 1'h0;
		end else begin
			sec_en_ff <= nxt_sec_en;
			conv_en_ff <= nxt_conv_en;
			hf_en_ff <= nxt_hf_en;
			// RQ6 external mode is ready at once, no start-up count
			sys_rdy_ff <= cfg_loaded_ff & (src_ext | (src_sec & sec_rdy)
				| (src_hf & hf_rdy_ff) | (src_lf & lf_rdy_ff));
			// RQ12 internal sources leave the input pin free
			gpio_in_ff <= cfg_loaded_ff & ~src_ext & ~src_sec;
			// RQ4 external clock level passed on as system clock
			ext_lvl_ff <= src_ext & clock_input_pin_sync_ff[1];
			ext_hp_ff <= src_ext & (ext_mode_ff == oscc_pkg::EXT_HIGH_POWER);
		end
	end

	// RQ7 all state sits in flops; a stopped clock just freezes it
	assign o_avs_readdata = rdata_ff;
	assign o_avs_waitrequest = wait_ff;
	assign o_sys_source = src_ff;
	assign o_sys_clock_ready = sys_rdy_ff;
	assign o_external_high_power_mode = ext_hp_ff;
	assign o_external_clock_level = ext_lvl_ff;
	assign o_clock_output_pin = pin_ff;
	assign o_clock_output_pin_oe = pin_oe_ff;
	assign o_clock_input_pin_is_gpio = gpio_in_ff;
	assign o_high_freq_internal_osc = hf_clk_ff;
	assign o_hf_trim_applied = trim_applied_ff;
	assign o_mid_500k_clock = clk500_ff;
	assign o_mid_31k25_clock = clk31_ff;
	assign o_fixed_1mhz_divided_clock = clk1m_ff;
	assign o_low_freq_internal_osc = clklf_ff;
	assign o_secondary_osc_en = sec_en_ff;
	assign o_secondary_osc_drive_select = drive_ff;
	assign o_converter_rc_osc_en = conv_en_ff;
	assign o_hf_osc_en = hf_en_ff;

	// Assertions
	localparam int LOCK_MAX = 45;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	AST_SRC_FIXED: // RQ1
	assert property ($past(cfg_loaded_ff) |-> $stable(src_ff)) else $error("source changed");
	AST_FREQ_CLEAR: // RQ21
	assert property (wr_freq |=> !hf_rdy_ff && $stable(hf_clk_ff)) else $error("ready not cleared");
	AST_FREQ_RELOCK: // RQ21
	assert property (wr_freq ##1 !wr_freq [*8] |-> ##[1:LOCK_MAX] hf_rdy_ff) else $error("no relock");
	AST_CLOCK_OUTPUT_PIN_ON: // RQ3
	assert property (cfg_loaded_ff && !clock_output_pin_en_n_ff |=> pin_oe_ff && pin_ff == $past(div4_ff))
		else $error("clock out missing");
	AST_CLOCK_OUTPUT_PIN_IO: // RQ12
	assert property (clock_output_pin_en_n_ff |=> pin_oe_ff == $past(i_gpio_out_oe)) else $error("pin not gpio");
	AST_SEC_EN: // RQ8
	assert property (cfg_loaded_ff && force_ff[oscc_pkg::FORCE_SEC_BIT] |=> sec_en_ff)
		else $error("secondary not enabled");
	AST_TRIM_SLEW: // RQ14
	assert property ($changed(trim_applied_ff) |-> (trim_applied_ff == $past(trim_applied_ff) + 6'h01)
		|| (trim_applied_ff == $past(trim_applied_ff) - 6'h01)) else $error("trim jumped");
	AST_CONV_EN: // RQ19
	assert property (i_converter_clk_request |=> conv_en_ff) else $error("converter rc off");
	AST_EXT_READY: // RQ6
	assert property (cfg_loaded_ff && src_ext |=> sys_rdy_ff) else $error("external not ready");
	AST_SEC_WAKE: // RQ24
	assert property (i_wake_pulse |=> !sec_rdy) else $error("secondary ready early");
	AST_ONE_MHZ: // RQ17
	assert property ($changed(clk1m_ff) && hf_en_ff |=> $stable(clk1m_ff) [*8]) else $error("1 MHz rate");
endmodule
`default_nettype wire

/* oscc_clock_source_model.sv */
// Far-side model: external logic-level clock and the 32 kHz crystal.
// Assumes the bench gates the external clock and the design drives the crystal.
`timescale 1ns/10ps
`default_nettype none
module oscc_clock_source_model #(
	parameter int EXT_HALF_NS = 80,
	parameter int XTAL_HALF_NS = 150
) (
	input wire logic i_ext_run,
	input wire logic i_xtal_run,
	output logic o_ext_clk,
	output logic o_xtal
);
	initial begin
		o_ext_clk = 1'b0;
		forever begin
			#(EXT_HALF_NS);
			if (i_ext_run) begin
				o_ext_clk = ~o_ext_clk;
			end
		end
	end
	// Crystal swings only while driven; much faster than 32 kHz to keep runs short
	initial begin
		o_xtal = 1'b0;
		forever begin
			#(XTAL_HALF_NS);
			if (i_xtal_run) begin
				o_xtal = ~o_xtal;
			end
		end
	end
endmodule
`default_nettype wire

/* test_oscc_source_control.sv */
// Self-checking testbench for the oscillator source control block.
// Assumes the clock source model on the pins and registers over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module test_oscc_source_control;
	// Bench-driven inputs, all valued at time zero
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0;
	logic [2:0] fuse_sel = 3'h6;
	logic [1:0] fuse_mode = 2'h1;
	logic fuse_ckout_n = 1'b0;
	logic gpio_data = 1'b0;
	logic gpio_oe = 1'b0;
	logic wake = 1'b0;
	logic por = 1'b0;
	logic conv_req = 1'b0;
	logic ext_run = 1'b0;
	// Design outputs and pins
	logic [31:0] avs_readdata;
	logic avs_waitrequest, ext_clk, xtal, sys_ready, ext_hp, ext_level, ck_pin, ck_oe, ck_gpio;
	logic hf_clk, c500k, c31k, c1m, lf_clk, sec_en, drive_sel, conv_en, hf_en;
	logic [2:0] sys_source;
	logic [5:0] trim_applied;
	int err_total = 0;
	int samples_checked = 0;
	int n;
	logic v;
	// Clocks measured by index
	wire logic [5:0] clks = {hf_clk, ck_pin, lf_clk, c31k, c500k, c1m};

	always #(oscc_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

	oscc_source_control uut (
		.i_clk(clk), .i_reset_n(reset_n), .i_avs_address(avs_address), .i_avs_read(avs_read),
		.i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_readdata),
		.o_avs_waitrequest(avs_waitrequest), .i_reset_clock_select(fuse_sel),
		.i_external_clock_mode_select(fuse_mode), .i_clock_output_enable_n(fuse_ckout_n),
		.i_clock_input_pin(ext_clk), .i_secondary_crystal_in(xtal), .i_gpio_out_data(gpio_data),
		.i_gpio_out_oe(gpio_oe), .i_wake_pulse(wake), .i_por_bor_pulse(por), .i_converter_clk_request(conv_req),
		.o_sys_source(sys_source), .o_sys_clock_ready(sys_ready), .o_external_high_power_mode(ext_hp),
		.o_external_clock_level(ext_level), .o_clock_output_pin(ck_pin), .o_clock_output_pin_oe(ck_oe),
		.o_clock_input_pin_is_gpio(ck_gpio), .o_high_freq_internal_osc(hf_clk),
		.o_hf_trim_applied(trim_applied), .o_mid_500k_clock(c500k), .o_mid_31k25_clock(c31k),
		.o_fixed_1mhz_divided_clock(c1m), .o_low_freq_internal_osc(lf_clk), .o_secondary_osc_en(sec_en),
		.o_secondary_osc_drive_select(drive_sel), .o_converter_rc_osc_en(conv_en), .o_hf_osc_en(hf_en)
	);

	oscc_clock_source_model src (.i_ext_run(ext_run), .i_xtal_run(sec_en), .o_ext_clk(ext_clk), .o_xtal(xtal));

	// Compare and count; four-state so an unknown never matches
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One Avalon access; request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clk);
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// Let an edge pass so the next call never drives a strobe twice in one step
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(s, q & m, e);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
		// One more edge so registers fed by the write show their new value
		step(1);
	endtask

	task automatic step(input int k);
		repeat (k) @(posedge clk);
	endtask

	// Fuses are sampled only at reset release, so each set needs a reset
	task automatic fuse_reset(input logic [2:0] sel, input logic [1:0] mode, input logic ckn);
		reset_n <= 1'b0;
		fuse_sel <= sel;
		fuse_mode <= mode;
		fuse_ckout_n <= ckn;
		step(12);
		reset_n <= 1'b1;
		step(4);
	endtask

	// Count cycles between two toggles of a clock
	task automatic half(input int k, input int exp, input string s);
		logic b;
		int c;
		b = clks[k];
		c = 0;
		while (clks[k] === b) begin
			@(posedge clk);
		end
		b = clks[k];
		while (clks[k] === b && c < 2000) begin
			@(posedge clk);
			c++;
		end
		check(s, c, exp);
	endtask

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Watchdog sized at about two and a half times the expected run
	initial begin
		step(40000);
		err_total++;
		complete_run();
	end

	initial begin
		fuse_reset(3'h6, 2'h1, 1'b0);
		check("sys source", sys_source, 32'h6);
		wr(8'h14, 32'h0);
		rd(8'h14, 32'hffffffff, 32'h6, "source after write");
		rd(8'h00, 32'hffffffff, 32'h0, "freq reset");
		rd(8'h04, 32'hffffffff, 32'h0, "trim reset");
		rd(8'h08, 32'hffffffff, 32'h1, "drive reset");
		rd(8'h0c, 32'hffffffff, 32'h0, "force reset");
		rd(8'h40, 32'hffffffff, 32'h0, "unmapped");
		check("clock_input_pin gpio", ck_gpio, 32'h1);
		check("clock_output_pin oe", ck_oe, 32'h1);
		half(4, 2, "clock_output_pin half");
		half(0, oscc_pkg::CLK_HZ / 2000000, "1mhz half");
		half(1, oscc_pkg::CLK_HZ / 1000000, "500k half");
		half(2, oscc_pkg::CLK_HZ / 62500, "31k25 half");
		half(3, oscc_pkg::CLK_HZ / 62000, "lf half");
		$display("Test 1 reset values and fixed clocks done");
		wr(8'h00, 32'h3);
		rd(8'h10, 32'h1, 32'h0, "hf ready cleared");
		v = hf_clk;
		n = 0;
		repeat (20) begin
			@(posedge clk);
			n += int'(hf_clk !== v);
		end
		check("hf held", n, 0);
		step(60);
		rd(8'h10, 32'h23, 32'h23, "hf ready again");
		half(5, 4, "hf half");
		$display("Test 2 frequency change done");
		wr(8'h04, 32'h3f);
		rd(8'h04, 32'hffffffff, 32'h3f, "trim readback");
		step(30);
		check("trim slew neg", trim_applied, 32'h3f);
		wr(8'h04, 32'h02);
		step(50);
		check("trim slew pos", trim_applied, 32'h02);
		half(3, oscc_pkg::CLK_HZ / 62000, "lf after trim");
		$display("Test 3 trim done");
		check("sec off", sec_en, 32'h0);
		wr(8'h08, 32'h0);
		check("drive low", drive_sel, 32'h0);
		wr(8'h0c, 32'h8);
		check("sec forced", sec_en, 32'h1);
		rd(8'h10, 32'h8, 32'h0, "sec not ready");
		step(5800);
		rd(8'h10, 32'h8, 32'h0, "sec short count");
		step(500);
		rd(8'h10, 32'h8, 32'h8, "sec ready");
		wake <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		rd(8'h10, 32'h8, 32'h0, "sec after wake");
		step(6400);
		rd(8'h10, 32'h8, 32'h8, "sec ready again");
		por <= 1'b1;
		@(posedge clk);
		por <= 1'b0;
		rd(8'h10, 32'h8, 32'h0, "sec after por");
		$display("Test 4 secondary start-up done");
		conv_req <= 1'b1;
		step(3);
		check("conv on request", conv_en, 32'h1);
		conv_req <= 1'b0;
		step(3);
		check("conv off", conv_en, 32'h0);
		wr(8'h0c, 32'h18);
		check("conv forced", conv_en, 32'h1);
		step(30);
		rd(8'h10, 32'h10, 32'h10, "conv ready");
		$display("Test 5 converter oscillator done");
		gpio_data <= 1'b1;
		gpio_oe <= 1'b1;
		ext_run <= 1'b1;
		fuse_reset(3'h7, 2'h3, 1'b1);
		check("ext high power", ext_hp, 32'h1);
		check("ext no delay", sys_ready, 32'h1);
		check("clock_input_pin not gpio", ck_gpio, 32'h0);
		check("clock_output_pin is io", ck_pin, 32'h1);
		check("clock_output_pin io oe", ck_oe, 32'h1);
		rd(8'h14, 32'hffffffff, 32'h7, "ext source");
		ext_run <= 1'b0;
		step(10);
		check("ext held", ext_level, ext_clk);
		ext_run <= 1'b1;
		gpio_oe <= 1'b0;
		step(3);
		check("clock_output_pin io off", ck_oe, 32'h0);
		fuse_reset(3'h7, 2'h1, 1'b1);
		check("ext low power", ext_hp, 32'h0);
		$display("Test 6 external clock done");
		fuse_reset(3'h4, 2'h1, 1'b1);
		check("sec by fuse", sec_en, 32'h1);
		rd(8'h14, 32'hffffffff, 32'h4, "sec source");
		fuse_reset(3'h0, 2'h1, 1'b0);
		rd(8'h00, 32'hffffffff, 32'h5, "32mhz freq");
		fuse_reset(3'h5, 2'h1, 1'b1);
		rd(8'h14, 32'hffffffff, 32'h5, "lf source");
		check("lf pins gpio", ck_gpio, 32'h1);
		wr(8'h0c, 32'h1);
		check("hf forced", hf_en, 32'h1);
		$display("Test 7 fuse selections done");
		complete_run();
	end
endmodule
`default_nettype wire
